/* inc/uie_pkg.sv */
package uie_pkg;
   // ----------------------------------------
   // register addresses on the 3-bit bus
   // ----------------------------------------
   localparam logic [2:0] ADR_DATA = 3'h0;
   localparam logic [2:0] ADR_MASK = 3'h1;
   localparam logic [2:0] ADR_SRC = 3'h2;
   localparam logic [2:0] ADR_LINE = 3'h5;
   localparam logic [2:0] ADR_MODEM = 3'h6;

   // ----------------------------------------
   // interrupt_mask_reg fields
   // ----------------------------------------
   localparam int MB_RXD = 0;
   localparam int MB_TXR = 1;
   localparam int MB_LINE = 2;
   localparam int MB_MODEM = 3;
   localparam int MB_SLEEP = 4;
   localparam int MB_XOFF = 5;
   localparam int MB_RTS = 6;
   localparam int MB_CTS = 7;
   localparam int MB_ENH_LO = 4;
   localparam logic [7:0] MASK_RST = 8'h00;

   // ----------------------------------------
   // line_state_reg fields
   // ----------------------------------------
   localparam int LS_DR = 0;
   localparam int LS_OVR = 1;
   localparam int LS_ERR_LO = 2;
   localparam int LS_THRE = 5;
   localparam int LS_TEMT = 6;
   localparam int LS_FERR = 7;

   // ----------------------------------------
   // fifo_setup_reg fields
   // ----------------------------------------
   localparam int FS_EN = 0;
   localparam int FS_TXT_LO = 4;
   localparam int FS_RXT_LO = 6;
   localparam int SR_FIFO_LO = 6;

   // trigger levels for selections 0..3
   localparam int TRIG_0 = 1;
   localparam int TRIG_1 = 4;
   localparam int TRIG_2 = 8;
   localparam int TRIG_3 = 14;

   // ----------------------------------------
   // source codes, index 0 is the highest level
   // ----------------------------------------
   localparam int NSRC = 7;
   localparam int PI_LINE = 0;
   localparam int PI_TMO = 1;
   localparam int PI_RXD = 2;
   localparam int PI_TXR = 3;
   localparam int PI_MODEM = 4;
   localparam int PI_XOFF = 5;
   localparam int PI_FLOW = 6;
   localparam logic [5:0] SRC_LINE = 6'h06;
   localparam logic [5:0] SRC_TMO = 6'h0C;
   localparam logic [5:0] SRC_RXD = 6'h04;
   localparam logic [5:0] SRC_TXR = 6'h02;
   localparam logic [5:0] SRC_MODEM = 6'h00;
   localparam logic [5:0] SRC_XOFF = 6'h10;
   localparam logic [5:0] SRC_FLOW = 6'h20;
   localparam logic [5:0] SRC_NONE = 6'h01;

   // ----------------------------------------
   // receive timeout: characters and extra bits
   // ----------------------------------------
   localparam int TO_CHARS = 4;
   localparam int TO_BITS = 12;
endpackage

/* inc/uie_if.sv */
`timescale 1ns/1ns
interface uie_if
   import uie_pkg::*;
   ();
   logic [NSRC-1:0] pend;
   logic [NSRC-1:0] onehot;
   logic [5:0] code;
   modport drv (output pend, input onehot, input code);
   modport enc (input pend, output onehot, output code);
endinterface

/* verilog/uie_prio.sv */
`timescale 1ns/1ns
module uie_prio
   import uie_pkg::*;
   (
   uie_if.enc bus
   );

   // ----------------------------------------
   // code table in level order
   // ----------------------------------------
   localparam logic [5:0] CODES [NSRC] =
      '{SRC_LINE, SRC_TMO, SRC_RXD, SRC_TXR, SRC_MODEM, SRC_XOFF, SRC_FLOW};

   always_comb
   begin
      bus.code = SRC_NONE;
      bus.onehot = '0;
      for (int i = NSRC - 1; i >= 0; i--)
      begin
         if (bus.pend[i])
         begin
            bus.code = CODES[i];
            bus.onehot = '0;
            bus.onehot[i] = 1'b1;
         end
      end
   end
endmodule

/* verilog/uie_top.sv */
`timescale 1ns/1ns
// Functional notes
// - fifo receive interrupt follows trigger level
// - data ready sets on push, clears empty
// - line state bits overrun, errors, empties
// - mask bit 0 enables receive data interrupt
// - mask bit 1 transmit ready, enable-when-empty
// - overrun immediate, other errors on readout
// - mask bit 3 modem deltas interrupt
// - upper mask bits need enhanced enable
// - rts and cts rising edges interrupt
// - timeout after four chars twelve bits
// - reported source holds until serviced
// - codes for levels one to four
// - codes for levels five to seven, none
// - transmit ready cleared by source read, write
// - rhr, line, modem reads clear theirs
// - xoff and special character clearing
// - flow interrupts cleared by modem read only
// - flow edges only under automatic control
// - source bit 0 low while pending
// - source bits 7:6 show fifo enable
// - source bits 5:4 need enhanced enable
// - fifo setup bit 0 enables fifos
module uie_top
   import uie_pkg::*;
   #(
   parameter int FIFO_DEPTH = 16,
   parameter int TMO_W = 8
   )
   (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [2:0] i_addr,
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   input wire logic i_dlab,
   input wire logic i_enh,
   input wire logic [$clog2(FIFO_DEPTH+1)-1:0] i_rx_count,
   input wire logic [$clog2(FIFO_DEPTH+1)-1:0] i_tx_count,
   input wire logic i_rx_push,
   input wire logic i_rx_overrun,
   input wire logic i_head_load,
   input wire logic [2:0] i_head_err,
   input wire logic i_fifo_err_any,
   input wire logic i_thr_empty,
   input wire logic i_tsr_empty,
   input wire logic i_bit_tick,
   input wire logic [3:0] i_char_bits,
   input wire logic [3:0] i_msr_delta,
   input wire logic i_xoff_det,
   input wire logic i_xon_det,
   input wire logic i_special_det,
   input wire logic i_auto_cts,
   input wire logic i_auto_rts,
   input wire logic i_cts_n,
   input wire logic i_rts_n,
   output logic [7:0] o_rdata,
   output logic o_irq,
   output logic o_fifo_en,
   output logic o_sleep_en
   );

   localparam int CW = $clog2(FIFO_DEPTH + 1);

   initial
   begin
      if (FIFO_DEPTH < TRIG_3 || TMO_W < 7)
         $error("uie_top: fifo depth or timer width too small");
   end

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   logic wr_mask;
   logic wr_fset;
   logic wr_thr;
   logic rd_src;
   logic rd_line;
   logic rd_modem;
   logic rd_rhr;

   assign wr_mask = i_wr && i_addr == ADR_MASK && !i_dlab;
   assign wr_fset = i_wr && i_addr == ADR_SRC;
   assign wr_thr = i_wr && i_addr == ADR_DATA && !i_dlab;
   assign rd_src = i_rd && i_addr == ADR_SRC;
   assign rd_line = i_rd && i_addr == ADR_LINE;
   assign rd_modem = i_rd && i_addr == ADR_MODEM;
   assign rd_rhr = i_rd && i_addr == ADR_DATA && !i_dlab;

   // ----------------------------------------
   // interrupt mask and fifo setup
   // ----------------------------------------
   logic [7:0] mask_r;
   logic fifo_en_r;
   logic [1:0] rx_sel_r;
   logic [1:0] tx_sel_r;

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         mask_r <= MASK_RST;
      else if (wr_mask)
      begin
         mask_r[MB_ENH_LO-1:0] <= i_wdata[MB_ENH_LO-1:0];
         if (i_enh)
            mask_r[7:MB_ENH_LO] <= i_wdata[7:MB_ENH_LO];
      end
   end

   // trigger bits only land while the enable bit is written as one
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         fifo_en_r <= 1'b0;
         rx_sel_r <= 2'h0;
         tx_sel_r <= 2'h0;
      end
      else if (wr_fset)
      begin
         fifo_en_r <= i_wdata[FS_EN];
         if (i_wdata[FS_EN])
         begin
            rx_sel_r <= i_wdata[FS_RXT_LO+:2];
            if (i_enh)
               tx_sel_r <= i_wdata[FS_TXT_LO+:2];
         end
      end
   end

   function automatic logic [CW-1:0] trig_of(input logic [1:0] sel);
      case (sel)
         2'h0: trig_of = CW'(TRIG_0);
         2'h1: trig_of = CW'(TRIG_1);
         2'h2: trig_of = CW'(TRIG_2);
         default: trig_of = CW'(TRIG_3);
      endcase
   endfunction

   // ----------------------------------------
   // line state
   // ----------------------------------------
   logic dr_r;
   logic ovr_r;
   logic [2:0] err_r;
   logic [7:0] line_state;

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         dr_r <= 1'b0;
      else if (i_rx_push)
         dr_r <= 1'b1;
      else if (i_rx_count == '0)
         dr_r <= 1'b0;
   end

   // a new error wins over the clearing read in the same cycle
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         ovr_r <= 1'b0;
         err_r <= 3'h0;
      end
      else
      begin
         ovr_r <= (ovr_r && !rd_line) || i_rx_overrun;
         err_r <= (rd_line ? 3'h0 : err_r) | (i_head_load ? i_head_err : 3'h0);
      end
   end

   always_comb
   begin
      line_state = 8'h00;
      line_state[LS_DR] = dr_r;
      line_state[LS_OVR] = ovr_r;
      line_state[LS_ERR_LO+:3] = err_r;
      line_state[LS_THRE] = i_thr_empty;
      line_state[LS_TEMT] = i_thr_empty && i_tsr_empty && i_tx_count == '0;
      line_state[LS_FERR] = i_fifo_err_any;
   end

   // ----------------------------------------
   // transmit ready
   // ----------------------------------------
   logic tx_cond;
   logic tx_cond_d_r;
   logic tx_set;
   logic txr_r;
   logic [5:0] show_code;

   assign tx_cond = fifo_en_r ? (i_tx_count < trig_of(tx_sel_r)) : i_thr_empty;
   assign tx_set = (tx_cond && !tx_cond_d_r)
                   || (tx_cond && wr_mask && i_wdata[MB_TXR] && !mask_r[MB_TXR]);

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         tx_cond_d_r <= 1'b0;
      else
         tx_cond_d_r <= tx_cond;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         txr_r <= 1'b0;
      else if (tx_set)
         txr_r <= 1'b1;
      else if (wr_thr || (rd_src && show_code == SRC_TXR))
         txr_r <= 1'b0;
   end

   // ----------------------------------------
   // receive timeout timer
   // ----------------------------------------
   logic [TMO_W-1:0] tmo_cnt_r;
   logic [TMO_W-1:0] tmo_limit;
   logic tmo_r;
   logic tmo_clr;
   logic tmo_fire;

   // the limit follows the live character length, so a format change rescales it
   assign tmo_limit = TMO_W'(TO_CHARS) * TMO_W'(i_char_bits) + TMO_W'(TO_BITS);
   assign tmo_clr = i_rx_push || rd_rhr || i_rx_count == '0 || !fifo_en_r;
   // set on the step that reaches the limit, so a saturated count cannot undo the clearing read
   assign tmo_fire = !tmo_clr && i_bit_tick && tmo_cnt_r == tmo_limit - TMO_W'(1);

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         tmo_cnt_r <= '0;
      else if (tmo_clr)
         tmo_cnt_r <= '0;
      else if (i_bit_tick && tmo_cnt_r != tmo_limit)
         tmo_cnt_r <= tmo_cnt_r + 1'b1;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         tmo_r <= 1'b0;
      else if (tmo_fire)
         tmo_r <= 1'b1;
      else if (rd_rhr)
         tmo_r <= 1'b0;
   end

   // ----------------------------------------
   // xoff or special character
   // ----------------------------------------
   logic xsp_r;
   logic xsp_special_r;

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         xsp_r <= 1'b0;
         xsp_special_r <= 1'b0;
      end
      else if (i_xoff_det || i_special_det)
      begin
         xsp_r <= 1'b1;
         xsp_special_r <= i_special_det;
      end
      else if ((rd_src && show_code == SRC_XOFF) || (!xsp_special_r && i_xon_det)
               || (xsp_special_r && i_rx_push))
         xsp_r <= 1'b0;
   end

   // ----------------------------------------
   // flow-control pin edges
   // ----------------------------------------
   logic cts_s1_r;
   logic cts_s2_r;
   logic cts_d_r;
   logic rts_d_r;
   logic cts_rise;
   logic rts_rise;
   logic flow_r;

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         cts_s1_r <= 1'b1;
         cts_s2_r <= 1'b1;
         cts_d_r <= 1'b1;
         rts_d_r <= 1'b1;
      end
      else
      begin
         cts_s1_r <= i_cts_n;
         cts_s2_r <= cts_s1_r;
         cts_d_r <= cts_s2_r;
         rts_d_r <= i_rts_n;
      end
   end

   assign cts_rise = cts_s2_r && !cts_d_r && i_auto_cts;
   assign rts_rise = i_rts_n && !rts_d_r && i_auto_rts;

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         flow_r <= 1'b0;
      else if ((mask_r[MB_CTS] && cts_rise) || (mask_r[MB_RTS] && rts_rise))
         flow_r <= 1'b1;
      else if (rd_modem)
         flow_r <= 1'b0;
   end

   // ----------------------------------------
   // pending sources and priority
   // ----------------------------------------
   uie_if pbus ();
   logic [NSRC-1:0] pend;
   logic hold_v_r;
   logic [NSRC-1:0] hold_sel_r;
   logic [5:0] hold_code_r;
   logic hold_live;
   logic rx_hit;

   // without fifos the holding register alone drives the receive interrupt
   assign rx_hit = fifo_en_r ? (i_rx_count >= trig_of(rx_sel_r)) : dr_r;

   always_comb
   begin
      pend = '0;
      pend[PI_LINE] = mask_r[MB_LINE] && (ovr_r || err_r != 3'h0);
      pend[PI_TMO] = mask_r[MB_RXD] && tmo_r;
      pend[PI_RXD] = mask_r[MB_RXD] && rx_hit;
      pend[PI_TXR] = mask_r[MB_TXR] && txr_r;
      pend[PI_MODEM] = mask_r[MB_MODEM] && i_msr_delta != 4'h0;
      pend[PI_XOFF] = i_enh && mask_r[MB_XOFF] && xsp_r;
      pend[PI_FLOW] = i_enh && flow_r;
   end

   assign pbus.pend = pend;

   uie_prio u_prio
   (
      .bus(pbus)
   );

   // a source shown by a read stays shown until its own cause goes away
   assign hold_live = hold_v_r && (hold_sel_r & pend) != '0;
   assign show_code = hold_live ? hold_code_r : pbus.code;

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         hold_v_r <= 1'b0;
         hold_sel_r <= '0;
         hold_code_r <= SRC_NONE;
      end
      else if (rd_src && !hold_live)
      begin
         hold_v_r <= pbus.code != SRC_NONE;
         hold_sel_r <= pbus.onehot;
         hold_code_r <= pbus.code;
      end
      else if (!hold_live)
         hold_v_r <= 1'b0;
   end

   // ----------------------------------------
   // read data and outputs
   // ----------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         o_rdata <= 8'h00;
      else if (i_rd)
      begin
         case (i_addr)
            ADR_MASK: o_rdata <= i_dlab ? 8'h00 : mask_r;
            ADR_SRC: o_rdata <= {{2{fifo_en_r}}, show_code};
            ADR_LINE: o_rdata <= line_state;
            default: o_rdata <= 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         o_irq <= 1'b0;
      else
         o_irq <= pend != '0;
   end

   assign o_fifo_en = fifo_en_r;
   assign o_sleep_en = mask_r[MB_SLEEP];

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_enable_empty;
      wr_mask && i_wdata[MB_TXR] && !mask_r[MB_TXR] && tx_cond;
   endsequence

   sequence s_src_read_flow;
      flow_r && rd_src && !rd_modem && !cts_rise && !rts_rise;
   endsequence

   AST_DR_SET: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_rx_push |=> dr_r)
      else $error("data ready missed a push");

   AST_DR_CLR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (dr_r && !i_rx_push && i_rx_count == '0) |=> !dr_r)
      else $error("data ready stuck with empty fifo");

   AST_RXD_TRIG: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (fifo_en_r && mask_r[MB_RXD] && i_rx_count < trig_of(rx_sel_r)) |-> !pend[PI_RXD])
      else $error("receive interrupt below trigger");

   AST_TXR_EN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_enable_empty |=> txr_r && pend[PI_TXR])
      else $error("enable while empty gave no interrupt");

   AST_TXR_CLR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (wr_thr && !tx_set) |=> !txr_r)
      else $error("holding write did not clear transmit ready");

   AST_MASK_ENH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (wr_mask && !i_enh) |=> mask_r[7:MB_ENH_LO] == $past(mask_r[7:MB_ENH_LO]))
      else $error("upper mask bits changed without enhanced enable");

   AST_FLOW_KEEP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_src_read_flow |=> flow_r)
      else $error("source read cleared flow interrupt");

   AST_IRQ: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (pend != '0) |=> o_irq)
      else $error("interrupt output not raised");

   AST_SRC_READ: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (rd_src && pend == '0 && !hold_live) |=> o_rdata[5:0] == SRC_NONE)
      else $error("idle source code wrong");

   AST_FIFO_BITS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      rd_src |=> o_rdata[7:6] == {2{$past(fifo_en_r)}})
      else $error("fifo enable bits wrong");

   AST_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (rd_src && pend[PI_TXR] && !wr_thr && !hold_live && !tx_set && !pend[PI_LINE]
       && !pend[PI_TMO] && !pend[PI_RXD]) |=> !txr_r)
      else $error("reported transmit source not serviced");
endmodule

/* tb/uie_host_model.sv */
`timescale 1ns/1ns
// --------------------------------------------------
// host side of the register bus
// --------------------------------------------------
// strobes change only at the falling edge, so the rising edge that takes them sees them settled
module uie_host_model
   (
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   output logic [2:0] o_addr,
   output logic o_rd,
   output logic o_wr,
   output logic [7:0] o_wdata
   );
   initial
   begin
      o_addr = 3'h0;
      o_rd = 1'b0;
      o_wr = 1'b0;
      o_wdata = 8'h00;
   end

   // polled use keeps mask bits 3:0 low; upper mask bits only follow the enhanced enable
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(negedge i_clk);
      o_wr = 1'b0;
      // released data lines show the inverse, not a stale copy
      o_wdata = ~d;
   endtask

   // read data is registered, so it is taken one cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(negedge i_clk);
      o_addr = a;
      o_rd = 1'b1;
      @(negedge i_clk);
      o_rd = 1'b0;
      d = i_rdata;
   endtask
endmodule

/* tb/tb_uie_top.sv */
`timescale 1ns/1ns
module tb_uie_top
   import uie_pkg::*;
   ;
   // --------------------------------------------------
   // signals
   // --------------------------------------------------
   localparam int TMO = TO_CHARS * 8 + TO_BITS;
   logic clk, rst_n, rd, wr, enh, push, ovr, hld, ferr, thre, tsre, tick;
   logic xoff, xon, spc, acts, arts, cts_n, rts_n, irq, fen, slp;
   logic [2:0] addr, herr;
   logic [7:0] wdata, rdata, d;
   logic [4:0] rxc, txc;
   logic [3:0] cbits, dlt;
   int err_count = 0;
   int compares = 0;

   always #10 clk = ~clk;

   uie_host_model host_u (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_rd(rd), .o_wr(wr),
      .o_wdata(wdata));

   uie_top dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_rd(rd), .i_wr(wr),
      .i_wdata(wdata), .i_dlab(1'b0), .i_enh(enh), .i_rx_count(rxc), .i_tx_count(txc),
      .i_rx_push(push), .i_rx_overrun(ovr), .i_head_load(hld), .i_head_err(herr),
      .i_fifo_err_any(ferr), .i_thr_empty(thre), .i_tsr_empty(tsre), .i_bit_tick(tick),
      .i_char_bits(cbits), .i_msr_delta(dlt), .i_xoff_det(xoff), .i_xon_det(xon),
      .i_special_det(spc), .i_auto_cts(acts), .i_auto_rts(arts), .i_cts_n(cts_n),
      .i_rts_n(rts_n), .o_rdata(rdata), .o_irq(irq), .o_fifo_en(fen), .o_sleep_en(slp));

   // --------------------------------------------------
   // helpers
   // --------------------------------------------------
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
      begin
         $display("DONE - PASS");
      end
      else
      begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   // three idle cycles first so registered flags and the irq output have settled
   task automatic rchk(input logic [2:0] a, input logic [7:0] e);
      logic [7:0] v;
      cyc(3);
      host_u.rd(a, v);
      chk(v, e, "register read");
   endtask

   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask

   task automatic ticks(input int n);
      repeat (n) pulse(tick);
   endtask

   task automatic tdone(input string m);
      $display("test %s finished at %0t", m, $time);
   endtask

   // --------------------------------------------------
   // watchdog
   // --------------------------------------------------
   // the sequence needs well under 2000 cycles
   initial
   begin
      repeat (10000) @(posedge clk);
      err_count++;
      $display("wrong value at %0t: run did not finish", $time);
      wrap_up();
   end

   // --------------------------------------------------
   // tests
   // --------------------------------------------------
   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      {enh, push, ovr, hld, ferr, tick, xoff, xon, spc, acts, arts} = 11'h000;
      {thre, tsre, cts_n, rts_n} = 4'hF;
      herr = 3'h0;
      rxc = 5'h00;
      txc = 5'h00;
      cbits = 4'h8;
      dlt = 4'h0;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      rchk(ADR_SRC, 8'h01);
      rchk(ADR_MASK, MASK_RST);
      rchk(3'h3, 8'h00);
      chk({7'h00, irq}, 8'h00, "irq after reset");
      tdone("reset");

      host_u.wr(ADR_MASK, 8'hFF);
      rchk(ADR_MASK, 8'h0F);
      chk({7'h00, irq}, 8'h01, "irq on enable while empty");
      rchk(ADR_SRC, 8'h02);
      rchk(ADR_SRC, 8'h01);
      host_u.wr(ADR_MASK, 8'h0D);
      host_u.wr(ADR_MASK, 8'h0F);
      host_u.wr(ADR_DATA, 8'h55);
      rchk(ADR_SRC, 8'h01);
      host_u.wr(ADR_MASK, 8'h0D);
      tdone("transmit ready");

      dlt = 4'h1;
      rchk(ADR_SRC, 8'h00);
      pulse(ovr);
      rchk(ADR_SRC, 8'h00);
      dlt = 4'h0;
      host_u.rd(ADR_MODEM, d);
      rchk(ADR_SRC, 8'h06);
      rchk(ADR_LINE, 8'h62);
      rchk(ADR_LINE, 8'h60);
      rchk(ADR_SRC, 8'h01);
      chk({7'h00, irq}, 8'h00, "irq after clears");
      tdone("priority");

      host_u.wr(ADR_SRC, 8'h01);
      rchk(ADR_SRC, 8'hC1);
      chk({7'h00, fen}, 8'h01, "fifo enable");
      rxc = 5'h1;
      pulse(push);
      rchk(ADR_SRC, 8'hC4);
      rchk(ADR_LINE, 8'h61);
      rxc = 5'h0;
      rchk(ADR_SRC, 8'hC1);
      rchk(ADR_LINE, 8'h60);
      tdone("receive fifo");

      host_u.wr(ADR_MASK, 8'h00);
      rxc = 5'h1;
      ferr = 1'b1;
      herr = 3'h1;
      pulse(push);
      pulse(hld);
      rchk(ADR_LINE, 8'hE5);
      chk({7'h00, irq}, 8'h00, "polled mode irq");
      host_u.wr(ADR_MASK, 8'h04);
      herr = 3'h4;
      pulse(hld);
      rchk(ADR_SRC, 8'hC6);
      rchk(ADR_LINE, 8'hF1);
      rchk(ADR_SRC, 8'hC1);
      {rxc, ferr, herr} = 9'h000;
      tdone("line errors");

      host_u.wr(ADR_SRC, 8'h41);
      host_u.wr(ADR_MASK, 8'h01);
      rxc = 5'h1;
      pulse(push);
      ticks(TMO - 4);
      rchk(ADR_SRC, 8'hC1);
      ticks(8);
      rchk(ADR_SRC, 8'hCC);
      host_u.rd(ADR_DATA, d);
      rchk(ADR_SRC, 8'hC1);
      rxc = 5'h0;
      tdone("timeout");

      enh = 1'b1;
      host_u.wr(ADR_MASK, 8'h20);
      pulse(xoff);
      rchk(ADR_SRC, 8'hD0);
      rchk(ADR_SRC, 8'hC1);
      pulse(xoff);
      pulse(xon);
      rchk(ADR_SRC, 8'hC1);
      pulse(spc);
      cyc(3);
      chk({7'h00, irq}, 8'h01, "special pending");
      pulse(push);
      rchk(ADR_SRC, 8'hC1);
      tdone("xoff");

      host_u.wr(ADR_MASK, 8'hD0);
      cts_n = 1'b0;
      cyc(6);
      cts_n = 1'b1;
      cyc(6);
      chk({7'h00, irq}, 8'h00, "cts edge without auto");
      chk({7'h00, slp}, 8'h01, "sleep enable");
      acts = 1'b1;
      cts_n = 1'b0;
      cyc(6);
      cts_n = 1'b1;
      cyc(4);
      rchk(ADR_SRC, 8'hE0);
      rchk(ADR_SRC, 8'hE0);
      host_u.rd(ADR_MODEM, d);
      rchk(ADR_SRC, 8'hC1);
      arts = 1'b1;
      rts_n = 1'b0;
      cyc(4);
      rts_n = 1'b1;
      rchk(ADR_SRC, 8'hE0);
      host_u.rd(ADR_MODEM, d);
      rchk(ADR_SRC, 8'hC1);
      tdone("flow control");

      txc = 5'h10;
      host_u.wr(ADR_SRC, 8'h31);
      host_u.wr(ADR_MASK, 8'h02);
      rchk(ADR_SRC, 8'hC1);
      txc = 5'h0D;
      rchk(ADR_SRC, 8'hC2);
      rchk(ADR_SRC, 8'hC1);
      txc = 5'h00;
      tdone("transmit trigger");

      host_u.wr(ADR_MASK, 8'hF0);
      enh = 1'b0;
      host_u.wr(ADR_MASK, 8'h00);
      rchk(ADR_MASK, 8'hF0);
      chk({7'h00, slp}, 8'h01, "sleep kept");
      pulse(xoff);
      rchk(ADR_SRC, 8'hC1);
      chk({7'h00, irq}, 8'h00, "xoff hidden");
      tdone("enhanced off");
      wrap_up();
   end
endmodule
